/* logic/rcide_regs.svh */
`ifndef RCIDE_REGS_SVH
`define RCIDE_REGS_SVH
// Register addresses on the plain register port.
`define RCIDE_A_CTRL 4'h0
`define RCIDE_A_STAGE 4'h1
`define RCIDE_A_VSTART 4'h2
`define RCIDE_A_HSTART 4'h3
`define RCIDE_A_BITW 4'h4
`define RCIDE_A_ONE 4'h5
`define RCIDE_A_ZERO 4'h6
`define RCIDE_A_STAT 4'h7
// Control register bit positions.
`define RCIDE_C_AUTO 0
`define RCIDE_C_RPT 1
`define RCIDE_C_DET 2
`define RCIDE_C_USER 3
`define RCIDE_C_RIC 4
`define RCIDE_C_DIG 5
`define RCIDE_C_TAG 6
`define RCIDE_C_NRT 7
// Reset values.
`define RCIDE_R_CTRL 8'h00
`define RCIDE_R_STAGE 2'h0
`define RCIDE_R_VSTART 8'h0a
`define RCIDE_R_HSTART 8'h40
`define RCIDE_R_BITW 8'h04
`define RCIDE_R_ONE 8'heb
`define RCIDE_R_ZERO 8'h10
`define RCIDE_R_HALF 10'h168
// Analog line framing.
`define RCIDE_RUNIN 16'haaaa
`define RCIDE_BITS_RIC 6'h34
`define RCIDE_BITS_NORIC 6'h24
// Digital line coding.
`define RCIDE_DIG_OFS 4'h5
`define RCIDE_DIG_START 8'h5e
`define RCIDE_DIG_END 8'h5f
`define RCIDE_IDX_DATA 6'h02
`define RCIDE_IDX_END 6'h2a
`define RCIDE_INFO_TOP 8'h9c
// Reserved timing-reference levels and their safe substitutes.
`define RCIDE_TRC_LO 8'h00
`define RCIDE_TRC_HI 8'hff
`define RCIDE_SAFE_LO 8'h01
`define RCIDE_SAFE_HI 8'hfe
`endif

/* logic/rcide_pkg.sv */
package rcide_pkg;
  // Kind of the blanking line being built; codes 0 to 5 are the type field.
  typedef enum logic [2:0] {
    K_AUTO = 3'b000, K_RPT = 3'b001, K_DET0 = 3'b010, K_DET1 = 3'b011,
    K_USR0 = 3'b100, K_USR1 = 3'b101, K_DIG = 3'b110, K_NONE = 3'b111
  } rcide_kind_type;
  // Inserter state.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_BITS = 2'b10, ST_DIG = 2'b11
  } rcide_st_type;
  // Configuration of one quarter of the record picture.
  typedef struct packed {
    logic valid;
    logic sequence_unit_flag;
    logic analog_switch_flag;
    logic [1:0] stage;
    logic [1:0] input_path_index;
  } rcide_region_type;
  // Detector flags of one channel.
  typedef struct packed {
    logic signal_lost_flag;
    logic movement_flag;
    logic covered_lens_flag;
    logic darkness_flag;
  } rcide_det_type;
  // One luma sample of the record stream with its timing.
  typedef struct packed {
    logic vblank;
    logic hactive;
    logic field;
    logic [7:0] y;
  } rcide_video_type;
endpackage

/* logic/rcide_encoder.sv */
`timescale 1ns/100ps
`include "rcide_regs.svh"
module rcide_encoder
  import rcide_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register port.
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Picture configuration and detector flags.
  input wire rcide_region_type [3:0] region_i,
  input wire logic [3:0] region_event_i,
  input wire rcide_det_type [3:0] input_set_a_i,
  input wire rcide_det_type [3:0] input_set_b_i,
  input wire logic lower_half_i,
  // Record stream.
  input wire rcide_video_type vid_i,
  output rcide_video_type vid_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_ff, vstart_ff, hstart_ff, bitw_ff, one_ff, zero_ff;
  logic [1:0] stage_ff;
  logic [7:0] user_ff [8];
  logic [7:0] rdata_ff;
  logic [3:0] ev_ff;
  rcide_video_type vid_d_ff, vid_o_ff;
  logic [7:0] blk_ff;
  logic [8:0] act_ff;
  logic [9:0] pix_ff, half_ff;
  rcide_kind_type kind_ff;
  rcide_st_type st_ff;
  logic [51:0] sh_ff;
  logic [5:0] left_ff;
  logic [7:0] bpix_ff;
  logic ins_ff;

  // Register writes steer the inserter.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff <= `RCIDE_R_CTRL;
      stage_ff <= `RCIDE_R_STAGE;
      vstart_ff <= `RCIDE_R_VSTART;
      hstart_ff <= `RCIDE_R_HSTART;
      bitw_ff <= `RCIDE_R_BITW;
      one_ff <= `RCIDE_R_ONE;
      zero_ff <= `RCIDE_R_ZERO;
      for (int i = 0; i < 8; i++) begin
        user_ff[i] <= 8'h00;
      end
    end else if (reg_wr_i) begin
      if (reg_addr_i[3]) begin
        user_ff[reg_addr_i[2:0]] <= reg_wdata_i;
      end else begin
        case (reg_addr_i)
          `RCIDE_A_CTRL: ctrl_ff <= reg_wdata_i;
          `RCIDE_A_STAGE: stage_ff <= reg_wdata_i[1:0];
          `RCIDE_A_VSTART: vstart_ff <= reg_wdata_i;
          `RCIDE_A_HSTART: hstart_ff <= reg_wdata_i;
          `RCIDE_A_BITW: bitw_ff <= reg_wdata_i;
          `RCIDE_A_ONE: one_ff <= reg_wdata_i;
          `RCIDE_A_ZERO: zero_ff <= reg_wdata_i;
          default: ;
        endcase
      end
    end
  end

  // Read data stand for one cycle after the strobe, zero otherwise.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
    end else if (!reg_rd_i) begin
      rdata_ff <= 8'h00;
    end else if (reg_addr_i[3]) begin
      rdata_ff <= user_ff[reg_addr_i[2:0]];
    end else begin
      case (reg_addr_i)
        `RCIDE_A_CTRL: rdata_ff <= ctrl_ff;
        `RCIDE_A_STAGE: rdata_ff <= {6'h00, stage_ff};
        `RCIDE_A_VSTART: rdata_ff <= vstart_ff;
        `RCIDE_A_HSTART: rdata_ff <= hstart_ff;
        `RCIDE_A_BITW: rdata_ff <= bitw_ff;
        `RCIDE_A_ONE: rdata_ff <= one_ff;
        `RCIDE_A_ZERO: rdata_ff <= zero_ff;
        `RCIDE_A_STAT: rdata_ff <= {1'b0, kind_ff, ev_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end
  end
  assign reg_rdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Line and pixel timing taken from the incoming stream.
  logic line_rise, line_fall;
  assign line_rise = vid_i.hactive & ~vid_d_ff.hactive;
  assign line_fall = ~vid_i.hactive & vid_d_ff.hactive;

  // Counts blanking lines, active lines and samples within a line.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vid_d_ff <= '0;
      blk_ff <= 8'h00;
      act_ff <= 9'h000;
      pix_ff <= 10'h000;
      half_ff <= `RCIDE_R_HALF;
    end else begin
      vid_d_ff <= vid_i;
      if (!vid_i.vblank) begin
        blk_ff <= 8'h00;
      end else if (line_rise && blk_ff != 8'hff) begin
        blk_ff <= blk_ff + 8'h01;
      end
      if (vid_i.vblank) begin
        act_ff <= 9'h000;
      end else if (line_fall) begin
        act_ff <= act_ff + 9'h001;
      end
      pix_ff <= vid_i.hactive ? pix_ff + 10'h001 : 10'h000;
      if (line_fall && !vid_i.vblank) begin
        half_ff <= {1'b0, pix_ff[9:1]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Information fields, byte zero in the top bits.
  logic [31:0] auto_w;
  logic [63:0] det_w, user_w;
  logic [31:0] nrt_w;
  logic [7:0] loc0, loc1;
  assign loc0 = {input_set_a_i[0], input_set_a_i[1]};
  assign loc1 = {input_set_a_i[2], input_set_a_i[3]};
  assign nrt_w = {loc0, loc1, input_set_b_i[0], input_set_b_i[1],
                  input_set_b_i[2], input_set_b_i[3]};

  // Builds auto, detect and user fields.
  always_comb begin
    for (int r = 0; r < 4; r++) begin
      auto_w[31 - 8 * r -: 8] = {region_i[r].valid, ev_ff[r],
                                 region_i[r].sequence_unit_flag,
                                 region_i[r].analog_switch_flag,
                                 region_i[r].stage,
                                 region_i[r].input_path_index};
    end
    for (int b = 0; b < 8; b++) begin
      user_w[63 - 8 * b -: 8] = user_ff[b];
      det_w[63 - 8 * b -: 8] = 8'h00;
    end
    det_w[63 - 16 * stage_ff -: 8] = loc0;
    det_w[55 - 16 * stage_ff -: 8] = loc1;
  end

  // Picks the kind of the next blanking line from the enabled slots.
  logic [6:0] slot_en;
  logic [7:0] rel;
  rcide_kind_type pick;
  assign slot_en = {ctrl_ff[`RCIDE_C_USER], ctrl_ff[`RCIDE_C_USER],
                    ctrl_ff[`RCIDE_C_DET] & ~ctrl_ff[`RCIDE_C_NRT],
                    ctrl_ff[`RCIDE_C_DET],
                    ctrl_ff[`RCIDE_C_AUTO] & ctrl_ff[`RCIDE_C_RPT],
                    ctrl_ff[`RCIDE_C_AUTO],
                    ctrl_ff[`RCIDE_C_DIG]};
  assign rel = blk_ff - vstart_ff;
  always_comb begin
    int cnt;
    cnt = 0;
    pick = K_NONE;
    if (blk_ff >= vstart_ff) begin
      for (int i = 0; i < 7; i++) begin
        if (slot_en[i]) begin
          if (cnt == int'(rel)) begin
            pick = (i == 0) ? K_DIG : rcide_kind_type'(3'(i - 1));
          end
          cnt = cnt + 1;
        end
      end
    end
  end

  // Four data bytes, type and parity of the picked line.
  logic [31:0] data_w;
  logic par;
  always_comb begin
    case (pick)
      K_AUTO, K_RPT: data_w = auto_w;
      K_DET0: data_w = ctrl_ff[`RCIDE_C_NRT] ? nrt_w : det_w[63:32];
      K_DET1: data_w = det_w[31:0];
      K_USR0: data_w = user_w[63:32];
      K_USR1: data_w = user_w[31:0];
      default: data_w = 32'h0000_0000;
    endcase
  end
  assign par = ^{data_w, pick};

  ////////////////////////////////////////////////////////////////////////////
  // Event flags stay pending until an auto line has carried them.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ev_ff <= 4'h0;
    end else begin
      for (int r = 0; r < 4; r++) begin
        if (region_event_i[r]) begin
          ev_ff[r] <= 1'b1;
        end else if (line_rise && vid_i.vblank && pick == K_AUTO) begin
          ev_ff[r] <= 1'b0;
        end
      end
    end
  end

  // Inserter state machine and bit serializer.
  logic last_pix;
  assign last_pix = (bpix_ff + 8'h01 >= bitw_ff);
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= ST_IDLE;
      kind_ff <= K_NONE;
      sh_ff <= '0;
      left_ff <= 6'h00;
      bpix_ff <= 8'h00;
    end else if (line_rise) begin
      kind_ff <= vid_i.vblank ? pick : K_NONE;
      bpix_ff <= 8'h00;
      if (!vid_i.vblank || pick == K_NONE) begin
        st_ff <= ST_IDLE;
      end else if (pick == K_DIG) begin
        st_ff <= ST_DIG;
      end else begin
        st_ff <= ST_WAIT;
        if (ctrl_ff[`RCIDE_C_RIC]) begin
          sh_ff <= {`RCIDE_RUNIN, data_w, pick, par};
          left_ff <= `RCIDE_BITS_RIC;
        end else begin
          sh_ff <= {data_w, pick, par, 16'h0000};
          left_ff <= `RCIDE_BITS_NORIC;
        end
      end
    end else if (!vid_i.hactive) begin
      st_ff <= ST_IDLE;
    end else begin
      case (st_ff)
        ST_WAIT: begin
          if (pix_ff + 10'h001 == {1'b0, hstart_ff, 1'b0}) begin
            st_ff <= ST_BITS; // First bit lands on sample 2*hstart.
          end
        end
        ST_BITS: begin
          if (last_pix) begin
            bpix_ff <= 8'h00;
            sh_ff <= {sh_ff[50:0], 1'b0};
            left_ff <= left_ff - 6'h01;
            if (left_ff == 6'h01) begin
              st_ff <= ST_IDLE;
            end
          end else begin
            bpix_ff <= bpix_ff + 8'h01;
          end
        end
        ST_DIG: st_ff <= ST_DIG;
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digital entry for the current sample; index wraps every 64 samples.
  logic [5:0] idx;
  logic [7:0] dig_y, nib_ofs;
  logic [159:0] info_w;
  assign idx = pix_ff[5:0];
  assign info_w = {auto_w, det_w, user_w};
  assign nib_ofs = `RCIDE_INFO_TOP - {idx - `RCIDE_IDX_DATA, 2'b00};
  always_comb begin
    if (idx < `RCIDE_IDX_DATA) begin
      dig_y = `RCIDE_DIG_START;
    end else if (idx < `RCIDE_IDX_END) begin
      dig_y = {`RCIDE_DIG_OFS, 4'(info_w >> nib_ofs)};
    end else begin
      dig_y = `RCIDE_DIG_END;
    end
  end

  // Boundary tag for the region whose left edge is at the current sample.
  logic [15:0] tag_w;
  logic [1:0] treg;
  logic at_left, at_right, tag_hit;
  assign at_left = pix_ff[9:1] == 9'h000;
  assign at_right = pix_ff[9:1] == half_ff[9:1];
  assign treg = {lower_half_i, at_right};
  assign tag_w = {act_ff, vid_i.field, region_i[treg].valid,
                  region_i[treg].analog_switch_flag, region_i[treg].stage,
                  region_i[treg].input_path_index};
  assign tag_hit = ctrl_ff[`RCIDE_C_TAG] & ~vid_i.vblank & vid_i.hactive
                   & (at_left | at_right);

  // Output sample selection with reserved codes kept out of inserted samples.
  logic [7:0] ins_y, safe_y;
  logic ins;
  always_comb begin
    ins = 1'b1;
    if (st_ff == ST_BITS && vid_i.hactive) begin
      ins_y = sh_ff[51] ? one_ff : zero_ff;
    end else if (vid_i.hactive && (st_ff == ST_DIG ||
                 (line_rise && vid_i.vblank && pick == K_DIG))) begin
      ins_y = dig_y; // Sample 0 is covered before the state settles.
    end else if (tag_hit) begin
      ins_y = pix_ff[0] ? tag_w[7:0] : tag_w[15:8];
    end else begin
      ins_y = vid_i.y;
      ins = 1'b0;
    end
    if (ins && ins_y == `RCIDE_TRC_LO) begin
      safe_y = `RCIDE_SAFE_LO;
    end else if (ins && ins_y == `RCIDE_TRC_HI) begin
      safe_y = `RCIDE_SAFE_HI;
    end else begin
      safe_y = ins_y;
    end
  end

  // Registered output stream, one cycle behind the input.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vid_o_ff <= '0;
      ins_ff <= 1'b0;
    end else begin
      vid_o_ff <= '{vblank: vid_i.vblank, hactive: vid_i.hactive,
                    field: vid_i.field, y: safe_y};
      ins_ff <= ins;
    end
  end
  assign vid_o = vid_o_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Checks next to the logic.
  AST_PARITY: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st_ff == ST_WAIT && $past(st_ff) != ST_WAIT) |->
      ^(ctrl_ff[`RCIDE_C_RIC] ? sh_ff[35:0] : sh_ff[51:16]) == 1'b0)
    else $error("analog line parity is not even");
  AST_TYPE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st_ff == ST_WAIT && $past(st_ff) != ST_WAIT && !ctrl_ff[`RCIDE_C_RIC])
      |-> sh_ff[19:17] == kind_ff)
    else $error("type field differs from line kind");
  AST_AUTO_FIRST: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (line_rise && vid_i.vblank && pick == K_AUTO && !ctrl_ff[`RCIDE_C_RIC])
      |=> sh_ff[51:46] == {$past(region_i[0].valid), $past(ev_ff[0]),
                           $past(region_i[0].sequence_unit_flag),
                           $past(region_i[0].analog_switch_flag),
                           $past(region_i[0].stage)})
    else $error("auto line does not open with top left region");
  AST_EVENT_SET: assert property (@(posedge core_clk_i) disable iff (rst_i)
    region_event_i[0] |=> ev_ff[0])
    else $error("event lost against clear");
  AST_NO_TRC: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ins_ff |-> (vid_o_ff.y != `RCIDE_TRC_LO && vid_o_ff.y != `RCIDE_TRC_HI))
    else $error("inserted sample equals a timing reference code");
  AST_DIG_START: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st_ff == ST_DIG && vid_i.hactive && pix_ff[5:0] == 6'h00 &&
     !line_rise) |=> vid_o_ff.y == `RCIDE_DIG_START ##1
      vid_o_ff.y == `RCIDE_DIG_START)
    else $error("digital sequence does not open with start code");
  AST_TAG_OFF: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!ctrl_ff[`RCIDE_C_TAG] && !vid_i.vblank && st_ff == ST_IDLE)
      |=> vid_o_ff.y == $past(vid_i.y))
    else $error("active sample altered with tag disabled");
  AST_BIT_WIDTH: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st_ff == ST_BITS && vid_i.hactive && bitw_ff > 8'h01 &&
     $stable(bitw_ff)) |-> bpix_ff < bitw_ff)
    else $error("bit stretched beyond programmed width");

endmodule

/* bench/rcide_rx_model.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Receiver of the record stream: keeps the luma of the latest active line.
module rcide_rx_model
  import rcide_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Record stream from the encoder.
  input wire rcide_video_type vid_i
);
  logic [7:0] line_y [0:511];
  int line_len;
  int trc_hits;
  logic hact_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Each active line is captured from index 0 at the rise of hactive.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_len <= 0;
      hact_ff <= 1'b0;
    end else begin
      hact_ff <= vid_i.hactive;
      if (vid_i.hactive && !hact_ff) begin
        line_y[0] <= vid_i.y;
        line_len <= 1;
      end else if (vid_i.hactive && line_len < 512) begin
        line_y[line_len] <= vid_i.y;
        line_len <= line_len + 1;
      end
    end
  end
  // A sync word inside active samples would break the receiver's timing.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trc_hits <= 0;
    end else if (vid_i.hactive && (vid_i.y == 8'h00 || vid_i.y == 8'hff)) begin
      trc_hits <= trc_hits + 1;
    end
  end
endmodule

/* bench/record_channel_id_encoder_tb_top.sv */
`timescale 1ns/100ps
`include "rcide_regs.svh"
module record_channel_id_encoder_tb_top import rcide_pkg::*;;
  logic core_clk_i, rst_i, reg_wr_i, reg_rd_i, lower_half_i;
  logic [3:0] reg_addr_i, region_event_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, lv1, lv0, tmp;
  logic [7:0] ub [0:7];
  logic [7:0] ib [0:19];
  rcide_region_type [3:0] region_i;
  rcide_det_type [3:0] input_set_a_i, input_set_b_i;
  rcide_video_type vid_i, vid_o;
  int fail_count, total_checks, hs, bw, st;
  ////////////////////////////////////////////////////////////////////////////
  // Design and stream receiver.
  rcide_encoder dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .region_i(region_i), .region_event_i(region_event_i),
    .input_set_a_i(input_set_a_i), .input_set_b_i(input_set_b_i),
    .lower_half_i(lower_half_i), .vid_i(vid_i), .vid_o(vid_o));
  rcide_rx_model rx (.core_clk_i(core_clk_i), .rst_i(rst_i), .vid_i(vid_o));
  // Free running 100 MHz clock.
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and bus helpers.
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // One line of n active samples at mid grey, then a short blank gap.
  task automatic send_line(input logic vb, input int n);
    for (int i = 0; i < n + 16; i++) begin
      @(posedge core_clk_i);
      vid_i <= {vb, i < n, 1'b1, (i < n) ? 8'h80 : 8'h10};
    end
  endtask
  function automatic logic [7:0] clamp8(input logic [7:0] x);
    return (x == 8'h00) ? 8'h01 : (x == 8'hff) ? 8'hfe : x;
  endfunction
  // Info bytes: four auto, eight detection, eight user.
  task automatic build(input logic [3:0] ev);
    rcide_region_type g;
    for (int r = 0; r < 4; r++) begin
      g = region_i[r];
      ib[r] = {g.valid, ev[r], g.sequence_unit_flag, g.analog_switch_flag,
               g.stage, g.input_path_index};
      ib[4+2*r] = (r == st) ? {input_set_a_i[0], input_set_a_i[1]} : 8'h00;
      ib[5+2*r] = (r == st) ? {input_set_a_i[2], input_set_a_i[3]} : 8'h00;
      ib[12+r] = ub[r];
      ib[16+r] = ub[4+r];
    end
  endtask
  // Compares a captured analog line against bytes ib[b..b+3].
  task automatic chk_an(input logic [2:0] ty, input int b, input logic ric);
    logic [51:0] v;
    logic [31:0] d;
    int n, p;
    d = {ib[b], ib[b+1], ib[b+2], ib[b+3]};
    v = {ric ? 16'haaaa : 16'h0000, d, ty, ^{d, ty}};
    n = ric ? 52 : 36;
    chk("pre", rx.line_y[2*hs-1], 8'h80);
    for (int k = 0; k < n; k++) begin
      for (int j = 0; j < bw; j++) begin
        p = 2 * hs + k * bw + j;
        chk("abit", rx.line_y[p], clamp8(v[n-1-k] ? lv1 : lv0));
      end
    end
    chk("post", rx.line_y[2*hs+n*bw], 8'h80);
  endtask
  function automatic logic [15:0] tagv(input int r, input int ln);
    rcide_region_type g;
    g = region_i[r];
    return {ln[8:0], 1'b1, g.valid, g.analog_switch_flag, g.stage,
            g.input_path_index};
  endfunction
  task automatic chk_tag(input int ln, input int r);
    logic [15:0] t;
    t = tagv(r, ln);
    chk("tag0", rx.line_y[0], clamp8(t[15:8]));
    chk("tag1", rx.line_y[1], clamp8(t[7:0]));
    t = tagv(r + 1, ln);
    chk("tag32", rx.line_y[32], clamp8(t[15:8]));
    chk("tag33", rx.line_y[33], clamp8(t[7:0]));
    chk("tagmid", rx.line_y[2], 8'h80);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_regs;
    logic [7:0] rv [0:6];
    rv = '{`RCIDE_R_CTRL, {6'h00, `RCIDE_R_STAGE}, `RCIDE_R_VSTART,
           `RCIDE_R_HSTART, `RCIDE_R_BITW, `RCIDE_R_ONE, `RCIDE_R_ZERO};
    for (int k = 0; k < 7; k++) begin
      rd(k[3:0], tmp);
      chk("reset", tmp, rv[k]);
    end
    for (int k = 0; k < 8; k++) begin
      ub[k] = {4'hc, k[3:0]};
      wr(4'h8 + k[3:0], ub[k]);
    end
    for (int k = 0; k < 8; k++) begin
      rd(4'h8 + k[3:0], tmp);
      chk("user", tmp, ub[k]);
    end
    wr(4'h7, 8'hff);
    rd(4'h7, tmp);
    chk("stat_ro", tmp[3:0], 4'h0);
  endtask
  task automatic t_event;
    wr(4'h0, 8'h01);
    wr(4'h2, 8'h01);
    @(posedge core_clk_i);
    region_event_i <= 4'b0011;
    @(posedge core_clk_i);
    region_event_i <= 4'b0000;
    rd(4'h7, tmp);
    chk("ev_set", tmp[3:0], 4'b0011);
    send_line(1'b0, 32);
    send_line(1'b1, 300);
    chk("noslot", rx.line_y[150], 8'h80);
    send_line(1'b1, 300);
    build(4'b0011);
    chk_an(3'd0, 0, 1'b0);
    rd(4'h7, tmp);
    chk("ev_clr", tmp[3:0], 4'b0000);
  endtask
  task automatic t_digital;
    logic [7:0] e;
    int m;
    wr(4'h0, 8'h21);
    wr(4'h2, 8'h00);
    build(4'h0);
    send_line(1'b0, 32);
    send_line(1'b1, 384);
    chk("dlen", rx.line_len[15:0], 16'd384);
    for (int i = 0; i < 384; i++) begin
      m = i % 64;
      if (m < 2) begin
        e = 8'h5e;
      end else if (m < 42) begin
        e = 8'h50 + ((m % 2) ? ib[(m-2)/2][3:0] : ib[(m-2)/2][7:4]);
      end else begin
        e = 8'h5f;
      end
      chk("dig", rx.line_y[i], e);
    end
    send_line(1'b1, 300);
    chk_an(3'd0, 0, 1'b0);
  endtask
  task automatic t_kinds;
    wr(4'h1, 8'h02);
    wr(4'h3, 8'h02);
    wr(4'h4, 8'h02);
    wr(4'h5, 8'hff);
    wr(4'h0, 8'h1f);
    st = 2;
    hs = 2;
    bw = 2;
    lv1 = 8'hff;
    build(4'h0);
    send_line(1'b0, 32);
    for (int k = 0; k < 6; k++) begin
      send_line(1'b1, 128);
      chk_an(k[2:0], (k < 2) ? 0 : 4 * (k - 1), 1'b1);
    end
  endtask
  task automatic t_nrt;
    wr(4'h0, 8'h84);
    send_line(1'b0, 32);
    send_line(1'b1, 128);
    ib[4] = {input_set_a_i[0], input_set_a_i[1]};
    ib[5] = {input_set_a_i[2], input_set_a_i[3]};
    ib[6] = {input_set_b_i[0], input_set_b_i[1]};
    ib[7] = {input_set_b_i[2], input_set_b_i[3]};
    chk_an(3'd2, 4, 1'b0);
    send_line(1'b1, 128);
    chk("nodet1", rx.line_y[10], 8'h80);
  endtask
  task automatic t_tag;
    wr(4'h0, 8'h40);
    send_line(1'b1, 64);
    chk("vflags", {vid_o.vblank, vid_o.field}, 2'b11);
    send_line(1'b0, 64);
    chk("vflags", {vid_o.vblank, vid_o.field}, 2'b01);
    send_line(1'b0, 64);
    chk_tag(1, 0);
    lower_half_i <= 1'b1;
    send_line(1'b0, 64);
    chk_tag(2, 2);
    wr(4'h0, 8'h00);
    send_line(1'b0, 64);
    chk("notag", rx.line_y[0], 8'h80);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    fail_count = 0;
    total_checks = 0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    lower_half_i = 1'b0;
    region_event_i = 4'h0;
    region_i = {7'h7f, 7'h4b, 7'h35, 7'h46};
    input_set_a_i = 16'h4321;
    input_set_b_i = 16'h8765;
    vid_i = '0;
    hs = 64;
    bw = 4;
    st = 0;
    lv1 = 8'heb;
    lv0 = 8'h10;
    rst_i = 1'b1;
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_event;
    t_digital;
    t_kinds;
    t_nrt;
    t_tag;
    chk("trc", rx.trc_hits[15:0], 16'h0000);
    test_done;
  end
  // Watchdog against a hung run.
  initial begin
    #900000;
    fail_count++;
    test_done;
  end
endmodule
